// File: pcsi_map.svh
`ifndef PCSI_MAP_SVH
`define PCSI_MAP_SVH

// register byte offsets on the bus
`define PCSI_OFS_LOW 5'h00
`define PCSI_OFS_HOLD 5'h04
`define PCSI_OFS_PTR 5'h08
`define PCSI_OFS_BANK 5'h0C
`define PCSI_OFS_PC 5'h10

// widths and depth
`define PCSI_PC_W 13
`define PCSI_LIT_W 11
`define PCSI_STK_D 8
`define PCSI_SP_W 3

// reset values
`define PCSI_PC_RST 13'h0000
`define PCSI_HOLD_RST 5'h00
`define PCSI_PTR_RST 8'h00
`define PCSI_BANK_RST 1'h0

// interrupt vector and the address of the indirect port
`define PCSI_INT_VEC 13'h0004
`define PCSI_IND_ADDR 7'h00
`endif

// File: pcsi_pkg.sv
package pcsi_pkg;
    // operation presented by the decode and execute logic, one per cycle
    typedef enum logic [3:0] {
        PCSI_OP_NOP = 4'b0000,
        PCSI_OP_INC = 4'b0001,
        PCSI_OP_WR_LOW = 4'b0010,
        PCSI_OP_ADD_LOW = 4'b0011,
        PCSI_OP_CALL = 4'b0100,
        PCSI_OP_JUMP = 4'b0101,
        PCSI_OP_RET = 4'b0110,
        PCSI_OP_INT = 4'b0111,
        PCSI_OP_WR_HOLD = 4'b1000,
        PCSI_OP_WR_PTR = 4'b1001,
        PCSI_OP_WR_BANK = 4'b1010
    } pcsi_op_t;

    typedef struct packed {
        pcsi_op_t op;
        logic [7:0] data;
        logic [10:0] lit;
    } pcsi_ctl_t;

    typedef struct packed {
        logic req;
        logic [6:0] addr;
    } pcsi_file_t;

    typedef struct packed {
        logic [8:0] addr;
        logic null_acc;
    } pcsi_eff_t;
endpackage : pcsi_pkg

// File: pcsi_top.sv
`timescale 1ns/1ps
`include "pcsi_map.svh"
module pcsi_top (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_soft_rst,
    input wire pcsi_pkg::pcsi_ctl_t i_ctl,
    input wire pcsi_pkg::pcsi_file_t i_file,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [12:0] o_pc,
    output logic [12:0] o_fetch_addr,
    output pcsi_pkg::pcsi_eff_t o_eff
);

////////////////////////////////////////////////////////////////////////////////
// program counter and the address handed to program memory
logic [`PCSI_PC_W-1:0] pc_q;
logic [`PCSI_PC_W-1:0] pc_d;
logic [`PCSI_PC_W-1:0] fetch_q;
logic [`PCSI_PC_W-1:0] fetch_d;
logic [`PCSI_PC_W-1:0] pc_inc;
logic [7:0] low_sum;

// holding latch for the upper bits, indirect pointer and its bank bit
logic [4:0] hold_q;
logic [7:0] ptr_q;
logic bank_q;

// return-address stack
logic [`PCSI_SP_W-1:0] sp_q;
logic [`PCSI_SP_W-1:0] sp_d;
logic [`PCSI_SP_W-1:0] sp_top;
logic [`PCSI_PC_W-1:0] stk_q [`PCSI_STK_D];
logic [`PCSI_PC_W-1:0] stk_rd;

// register bus
logic wait_q;
logic [31:0] rdata_q;
logic [31:0] rdata_d;
logic bus_req;
logic bus_wr;
logic bus_rd;
logic bus_wr_low;
logic bus_wr_hold;
logic bus_wr_ptr;
logic bus_wr_bank;

// operation decode
logic op_idle;
logic op_wr_hold;
logic op_wr_ptr;
logic op_wr_bank;
logic push;
logic pop;

// operand addressing
pcsi_pkg::pcsi_eff_t eff_d;
pcsi_pkg::pcsi_eff_t eff_q;
logic ind_sel;
logic self_ref;

////////////////////////////////////////////////////////////////////////////////
// operation decode
// one operation arrives per cycle; these strobes keep the per-register
// processes short and make the priority between core and bus explicit
assign op_idle = (i_ctl.op == pcsi_pkg::PCSI_OP_NOP);
assign op_wr_hold = (i_ctl.op == pcsi_pkg::PCSI_OP_WR_HOLD);
assign op_wr_ptr = (i_ctl.op == pcsi_pkg::PCSI_OP_WR_PTR);
assign op_wr_bank = (i_ctl.op == pcsi_pkg::PCSI_OP_WR_BANK);

// calls and interrupt entry push, every return kind pops
assign push = (i_ctl.op == pcsi_pkg::PCSI_OP_CALL) || (i_ctl.op == pcsi_pkg::PCSI_OP_INT);
assign pop = (i_ctl.op == pcsi_pkg::PCSI_OP_RET);

////////////////////////////////////////////////////////////////////////////////
// bus handshake
// every access costs exactly one wait state: the request is taken while
// waitrequest is high and completes on the following edge with it low
assign bus_req = i_avs_read | i_avs_write;
assign bus_wr = i_avs_write & ~wait_q;
assign bus_rd = i_avs_read & wait_q;

// write strobes per register, valid only in the completing cycle
assign bus_wr_low = bus_wr && (i_avs_address == `PCSI_OFS_LOW);
assign bus_wr_hold = bus_wr && (i_avs_address == `PCSI_OFS_HOLD);
assign bus_wr_ptr = bus_wr && (i_avs_address == `PCSI_OFS_PTR);
assign bus_wr_bank = bus_wr && (i_avs_address == `PCSI_OFS_BANK);

// waitrequest idles high so a master never sees a phantom completion
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        wait_q <= 1'b1;
    end else if (bus_req && wait_q) begin
        wait_q <= 1'b0;
    end else begin
        wait_q <= 1'b1;
    end
end

// read mux; the counter readback is read-only and has no write strobe
always_comb begin
    rdata_d = 32'h00000000;
    case (i_avs_address)
        `PCSI_OFS_LOW: rdata_d = {24'h000000, pc_q[7:0]};
        `PCSI_OFS_HOLD: rdata_d = {27'h0000000, hold_q};
        `PCSI_OFS_PTR: rdata_d = {24'h000000, ptr_q};
        `PCSI_OFS_BANK: rdata_d = {31'h00000000, bank_q};
        `PCSI_OFS_PC: rdata_d = {19'h00000, pc_q};
        default: rdata_d = 32'h00000000; // unmapped reads as zero
    endcase
end

// read data captured in the wait cycle so it stands when waitrequest drops;
// it then holds until the next read so a slow master still sees it
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        rdata_q <= 32'h00000000;
    end else if (bus_rd) begin
        rdata_q <= rdata_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// stack pointer
// no flag reports over- or under-run: the pointer simply wraps modulo
// eight, so software that nests too deeply loses its oldest return address
assign sp_top = sp_q - 3'h1;
assign stk_rd = stk_q[sp_top];

always_comb begin
    sp_d = sp_q;
    if (push) begin
        sp_d = sp_q + 3'h1;
    end else if (pop) begin
        sp_d = sp_top;
    end
end

// the pointer is never mapped on the bus, so software cannot see it
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        sp_q <= 3'h0;
    end else if (i_soft_rst) begin
        sp_q <= 3'h0;
    end else begin
        sp_q <= sp_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// stack entries
// each entry is written only when the pointer selects it, so the ninth
// push lands on slot 0 again; a soft reset in the same cycle blocks it
generate
    for (genvar gi = 0; gi < `PCSI_STK_D; gi++) begin : g_stk
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                stk_q[gi] <= `PCSI_PC_RST;
            end else if (push && !i_soft_rst && (sp_q == 3'(gi))) begin
                stk_q[gi] <= pc_q;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// next program counter
// the computed jump adds only into the low byte: a table that crosses a
// 256-location boundary wraps back to its block start, by design
assign low_sum = pc_q[7:0] + i_ctl.data; // carry dropped on purpose
assign pc_inc = pc_q + 13'h0001;

// core operations win over a bus write to the low byte, which is taken
// only in a cycle with no operation so an instruction flow is never torn
always_comb begin
    pc_d = pc_q;
    case (i_ctl.op)
        pcsi_pkg::PCSI_OP_NOP: begin
            if (bus_wr_low) begin
                pc_d = {hold_q, i_avs_writedata[7:0]};
            end
        end
        pcsi_pkg::PCSI_OP_INC: pc_d = pc_inc;
        pcsi_pkg::PCSI_OP_WR_LOW: pc_d = {hold_q, i_ctl.data};
        pcsi_pkg::PCSI_OP_ADD_LOW: pc_d = {hold_q, low_sum};
        pcsi_pkg::PCSI_OP_CALL,
        pcsi_pkg::PCSI_OP_JUMP: pc_d = {hold_q[4:3], i_ctl.lit};
        pcsi_pkg::PCSI_OP_RET: pc_d = stk_rd;
        pcsi_pkg::PCSI_OP_INT: pc_d = `PCSI_INT_VEC;
        default: pc_d = pc_q; // register writes leave the counter alone
    endcase
end

// only one program page exists, so the paging bits never reach memory;
// they still stand in the counter and on the stack as software left them
assign fetch_d = {2'b00, pc_d[10:0]};

// counter register; both reset kinds clear it
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        pc_q <= `PCSI_PC_RST;
    end else if (i_soft_rst) begin
        pc_q <= `PCSI_PC_RST;
    end else begin
        pc_q <= pc_d;
    end
end

// fetch address register, loaded from the same next value as the counter
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        fetch_q <= `PCSI_PC_RST;
    end else if (i_soft_rst) begin
        fetch_q <= `PCSI_PC_RST;
    end else begin
        fetch_q <= fetch_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// holding latch
// only explicit writes touch it, never push or pop, so a return lands in
// the caller's page while the latch still holds what software last put there
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        hold_q <= `PCSI_HOLD_RST;
    end else if (op_wr_hold) begin
        hold_q <= i_ctl.data[4:0];
    end else if (bus_wr_hold) begin
        hold_q <= i_avs_writedata[4:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// indirect pointer
// a core write and a bus write in one cycle: the core wins, the bus
// access still completes but its data is lost
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        ptr_q <= `PCSI_PTR_RST;
    end else if (op_wr_ptr) begin
        ptr_q <= i_ctl.data;
    end else if (bus_wr_ptr) begin
        ptr_q <= i_avs_writedata[7:0];
    end
end

// bank bit is stored but has no effect on this part's memory; it shows up
// as the top bit of the effective address and in its bus readback
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        bank_q <= `PCSI_BANK_RST;
    end else if (op_wr_bank) begin
        bank_q <= i_ctl.data[7];
    end else if (bus_wr_bank) begin
        bank_q <= i_avs_writedata[0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// operand address resolution
// the indirect port has no storage: naming it selects the register the
// pointer holds; a pointer of zero would point back at the port itself
assign ind_sel = (i_file.addr == `PCSI_IND_ADDR);
assign self_ref = (ptr_q == 8'h00);

// the null flag tells the core to read 00h and to drop the write; status
// flag updates of the instruction stay with the core and may still happen
always_comb begin
    eff_d = '0;
    if (ind_sel) begin
        eff_d.addr = {bank_q, ptr_q};
        eff_d.null_acc = self_ref;
    end else begin
        eff_d.addr = {2'b00, i_file.addr};
        eff_d.null_acc = 1'b0;
    end
end

// answer one cycle after the request, held until the next request
always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        eff_q <= '0;
    end else if (i_file.req) begin
        eff_q <= eff_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs, all straight from registers
assign o_pc = pc_q;
assign o_fetch_addr = fetch_q;
assign o_eff = eff_q;
assign o_avs_readdata = rdata_q;
assign o_avs_waitrequest = wait_q;

endmodule : pcsi_top

// File: pcsi_top_asserts.sv
`timescale 1ns/1ps
module pcsi_top_asserts (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_soft_rst,
    input wire pcsi_pkg::pcsi_ctl_t i_ctl,
    input wire pcsi_pkg::pcsi_file_t i_file,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire logic [12:0] o_pc,
    input wire logic [12:0] o_fetch_addr,
    input wire pcsi_pkg::pcsi_eff_t o_eff
);
    // a soft reset or a bus write would legally disturb the counter
    wire q = !i_soft_rst && !i_avs_write;
    wire [3:0] op = i_ctl.op;
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////
    chk_jump_lit: assert property (op == pcsi_pkg::PCSI_OP_JUMP && q |=> o_pc[10:0] == $past(i_ctl.lit))
        else $error("jump literal not loaded");
    chk_fetch_page: assert property (o_fetch_addr == {2'b00, o_pc[10:0]})
        else $error("fetch uses paging bits");
    chk_soft_clear: assert property (i_soft_rst |=> o_pc == 13'h0000)
        else $error("soft reset left counter");
    chk_int_vector: assert property (op == pcsi_pkg::PCSI_OP_INT && q |=> o_pc == 13'h0004)
        else $error("interrupt missed vector");
    chk_add_block: assert property (op == pcsi_pkg::PCSI_OP_ADD_LOW && q |=>
        o_pc[7:0] == 8'($past(o_pc[7:0]) + $past(i_ctl.data))) else $error("computed jump wrong");
    chk_wr_low: assert property (op == pcsi_pkg::PCSI_OP_WR_LOW && q |=> o_pc[7:0] == $past(i_ctl.data))
        else $error("low byte not loaded");
    chk_call_ret: assert property ((op == pcsi_pkg::PCSI_OP_CALL && q) ##1 (op == 4'h0 && q) ##1
        (op == pcsi_pkg::PCSI_OP_RET && q) |=> o_pc == $past(o_pc, 3)) else $error("return address lost");
    chk_bus_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus answer late");
    chk_eff_direct: assert property (i_file.req && i_file.addr != 7'h00 |=>
        o_eff == {2'b00, $past(i_file.addr), 1'b0}) else $error("direct address wrong");
    cover property (op == pcsi_pkg::PCSI_OP_INT);
    cover property (o_eff.null_acc);
    cover property (i_avs_write && !o_avs_waitrequest);
endmodule : pcsi_top_asserts
bind pcsi_top pcsi_top_asserts u_chk (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_soft_rst(i_soft_rst),
    .i_ctl(i_ctl), .i_file(i_file), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_waitrequest(o_avs_waitrequest), .o_pc(o_pc), .o_fetch_addr(o_fetch_addr), .o_eff(o_eff));

// File: pcsi_core_model.sv
`timescale 1ns/1ps
module pcsi_core_model (
    input wire logic i_core_clk,
    output pcsi_pkg::pcsi_ctl_t o_ctl,
    output pcsi_pkg::pcsi_file_t o_file
);
    // idle core: no operation and no operand access
    initial begin
        o_ctl = '0;
        o_file = '0;
    end
    // one instruction for one cycle, then idle so bus writes may land
    task automatic issue(input pcsi_pkg::pcsi_op_t op, input logic [7:0] d, input logic [10:0] l);
        @(posedge i_core_clk);
        o_ctl <= '{op, d, l};
        @(posedge i_core_clk);
        o_ctl <= '0;
        #1;
    endtask : issue
    // operand access, a one-cycle pulse
    task automatic access(input logic [6:0] a);
        @(posedge i_core_clk);
        o_file <= '{1'b1, a};
        @(posedge i_core_clk);
        o_file <= '0;
        #1;
    endtask : access
endmodule : pcsi_core_model

// File: pcsi_top_tb_top.sv
`timescale 1ns/1ps
module pcsi_top_tb_top;
    logic clk, rst_n, srst, rd, wr, wt;
    logic [4:0] adr;
    logic [31:0] wdat, rdat, got;
    logic [12:0] pc, fa;
    pcsi_pkg::pcsi_ctl_t ctl;
    pcsi_pkg::pcsi_file_t fl;
    pcsi_pkg::pcsi_eff_t eff;
    int n_fail = 0;
    int n_compared = 0;
    pcsi_core_model core (.i_core_clk(clk), .o_ctl(ctl), .o_file(fl));
    pcsi_top uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_soft_rst(srst), .i_ctl(ctl), .i_file(fl),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .o_pc(pc), .o_fetch_addr(fa), .o_eff(eff));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (wt !== 1'b0) @(posedge clk);
        got = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////
    task automatic t_bus();
        chk(pc, 0);
        bus(0, 5'h14, 0);
        chk(got, 0);
        bus(1, 5'h04, 32'h1F);
        bus(1, 5'h00, 32'h5A);
        bus(0, 5'h10, 0);
        chk(got, 32'h1F5A);
        chk(fa, 13'h075A);
        bus(0, 5'h00, 0);
        chk(got, 32'h5A);
        core.issue(pcsi_pkg::PCSI_OP_ADD_LOW, 8'hB0, 0);
        chk(pc, 13'h1F0A);
        $display("bus test done");
    endtask : t_bus
    task automatic t_flow();
        core.issue(pcsi_pkg::PCSI_OP_CALL, 0, 11'h123);
        chk(pc, 13'h1923);
        core.issue(pcsi_pkg::PCSI_OP_RET, 0, 0);
        chk(pc, 13'h1F0A);
        bus(0, 5'h04, 0);
        chk(got, 32'h1F);
        core.issue(pcsi_pkg::PCSI_OP_INT, 0, 0);
        chk(pc, 13'h0004);
        core.issue(pcsi_pkg::PCSI_OP_RET, 0, 0);
        chk(pc, 13'h1F0A);
        $display("flow test done");
    endtask : t_flow
    // nine calls overrun the eight entries, popping wraps silently
    task automatic t_wrap();
        core.issue(pcsi_pkg::PCSI_OP_WR_HOLD, 0, 0);
        for (int k = 1; k <= 9; k++) core.issue(pcsi_pkg::PCSI_OP_CALL, 0, 11'(16 + k));
        for (int i = 1; i <= 9; i++) begin
            core.issue(pcsi_pkg::PCSI_OP_RET, 0, 0);
            chk(pc, 13'hF + (i == 9 ? 9 : 10 - i));
        end
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        #1;
        chk(pc, 0);
        $display("wrap test done");
    endtask : t_wrap
    task automatic t_ind();
        core.access(7'h00);
        chk(eff, 10'h001);
        core.access(7'h25);
        chk(eff, {9'h025, 1'b0});
        core.issue(pcsi_pkg::PCSI_OP_WR_PTR, 8'h3C, 0);
        core.issue(pcsi_pkg::PCSI_OP_WR_BANK, 8'h80, 0);
        core.access(7'h00);
        chk(eff, {9'h13C, 1'b0});
        $display("indirect test done");
    endtask : t_ind
    initial begin
        {rst_n, srst, rd, wr, adr, wdat} = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_bus();
        t_flow();
        t_wrap();
        t_ind();
        wrap_up();
    end
    // hang guard, far beyond the roughly one hundred cycles of the run
    initial begin
        #50000;
        n_fail++;
        wrap_up();
    end
endmodule : pcsi_top_tb_top
